// >>> bench/tir_host_model.sv
// host processor bus model with acknowledge handshake
`timescale 1ns/1ns
module tir_host_model
(
	// clock
	input wire logic        clk,
	// bus toward the block
	output logic            chip_select,
	output logic            addr_strobe_n,
	output logic            read_not_write,
	output logic [3:0]      register_select,
	output logic [7:0]      data_in,
	input  wire logic [7:0] data_out,
	input  wire logic       data_ack_n
);
	int slow = 0; // idle cycles before a request, slow host
	initial
	begin
		chip_select = 0;
		addr_strobe_n = 1;
		read_not_write = 1;
		register_select = 4'h0;
		data_in = 8'h00;
	end
	// one access; request held until the acknowledge edge
	task automatic access(input logic r, input logic [3:0] s, input logic [7:0] d,
		output logic [7:0] q, output bit ok);
		int n;
		n = 0;
		repeat (slow) @(posedge clk);
		#1 chip_select = 1;
		addr_strobe_n = 0;
		read_not_write = r;
		register_select = s;
		data_in = d;
		do
		begin
			@(posedge clk);
			n++;
		end
		while (data_ack_n !== 1'b0 && n < 40);
		q = data_out;
		ok = (n < 40);
		// released bus shows the inverse, never the old value
		#1 chip_select = 0;
		addr_strobe_n = 1;
		read_not_write = ~r;
		register_select = ~s;
		data_in = ~d;
		repeat (3) @(posedge clk);
	endtask : access
endmodule : tir_host_model

// >>> bench/tir_timer_irq_chk.sv
// concurrent checks on the timer and interrupt block ports
`timescale 1ns/1ns
module tir_timer_irq_chk
	import tir_pkg::*;
(
	// clock and reset
	input wire logic       clk,
	input wire logic       reset,
	// processor bus
	input wire logic       chip_select,
	input wire logic       addr_strobe_n,
	input wire logic       read_not_write,
	input wire logic [3:0] register_select,
	input wire logic [7:0] data_in,
	input wire logic [7:0] data_out,
	input wire logic       data_ack_n,
	// lines and request
	input wire logic       port_a_primary_line,
	input wire logic       port_a_secondary_line,
	input wire logic       shift_clock_line,
	input wire logic       serial_in_line,
	input wire logic       serial_out_line,
	input wire logic       irq_n
);
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (reset);
	// host opens an access
	sequence s_start;
		$rose(chip_select) && !addr_strobe_n;
	endsequence
	// acknowledge held off, then given inside the window
	sequence s_ack_wait;
		data_ack_n [*6] ##[1:12] !data_ack_n;
	endsequence
	// a read of one register completes
	sequence s_rd(logic [3:0] code);
		$fell(data_ack_n) && read_not_write && register_select == code;
	endsequence
	a_ack_latency: assert property (s_start |-> s_ack_wait)
		else $error("acknowledge outside its window");
	a_ack_release: assert property (!data_ack_n && !chip_select |-> ##[1:2] data_ack_n)
		else $error("acknowledge held after select dropped");
	a_ack_no_cs: assert property (!chip_select ##1 !chip_select |-> data_ack_n)
		else $error("acknowledge without select");
	a_reset_quiet: assert property (disable iff (1'b0) reset |=> irq_n && data_ack_n)
		else $error("outputs active after reset");
	a_enable_read: assert property (s_rd(REG_ENABLES) |-> data_out[ENA_SET])
		else $error("enable read top bit low");
	a_port_read: assert property (s_rd(REG_PORT_A) |-> data_out == 8'h00)
		else $error("port read not zero");
	a_summary_bit: assert property (s_rd(REG_FLAGS) ##0 data_out[6:0] == 7'h00 |-> !data_out[FLG_IRQ])
		else $error("summary set with no flag");
	// data out moves only after a fall of the shift clock
	a_shift_hold: assert property ((shift_clock_line && !chip_select) [*5] |-> $stable(serial_out_line))
		else $error("serial out moved with clock high");
endmodule : tir_timer_irq_chk
bind tir_timer_irq tir_timer_irq_chk chk_u (.clk(clk), .reset(reset), .chip_select(chip_select),
	.addr_strobe_n(addr_strobe_n), .read_not_write(read_not_write),
	.register_select(register_select), .data_in(data_in), .data_out(data_out),
	.data_ack_n(data_ack_n), .port_a_primary_line(port_a_primary_line),
	.port_a_secondary_line(port_a_secondary_line), .shift_clock_line(shift_clock_line),
	.serial_in_line(serial_in_line), .serial_out_line(serial_out_line), .irq_n(irq_n));

// >>> bench/tir_timer_irq_test.sv
// self-checking bench for the timer and interrupt block
`timescale 1ns/1ns
module tir_timer_irq_test;
	import tir_pkg::*;
	typedef struct {logic r; logic [3:0] s; logic [7:0] d; logic [7:0] e;} tir_row_t;
	logic       clk = 0, reset = 1, pa1 = 0, pa2 = 0, sclk = 1, sdin = 0;
	logic       cs, as_n, rnw, ack_n, irq_n, sout;
	logic [3:0] sel;
	logic [7:0] din, dout, sq;
	int         err_count = 0, checks = 0, cyc = 0;
	// ordinary accesses: read rows carry the expected byte
	tir_row_t rows [13] = '{
		'{0, REG_ENABLES, 8'hFF, 0}, '{1, REG_ENABLES, 0, 8'hFF},
		'{0, REG_ENABLES, 8'h05, 0}, '{1, REG_ENABLES, 0, 8'hFA},
		'{0, REG_ENABLES, 8'h7F, 0}, '{1, REG_ENABLES, 0, 8'h80},
		'{0, REG_T1_CNT_LO, 8'h34, 0}, '{0, REG_T1_LAT_HI, 8'h12, 0},
		'{1, REG_T1_LAT_LO, 0, 8'h34}, '{1, REG_T1_LAT_HI, 0, 8'h12},
		'{0, REG_T2_CNT_LO, 8'hFF, 0}, '{0, REG_T2_CNT_HI, 8'h40, 0},
		'{1, REG_T2_CNT_HI, 0, 8'h40}};
	always #50 clk = ~clk;
	tir_timer_irq dut_u (.clk(clk), .reset(reset), .chip_select(cs), .addr_strobe_n(as_n),
		.read_not_write(rnw), .register_select(sel), .data_in(din), .data_out(dout),
		.data_ack_n(ack_n), .port_a_primary_line(pa1), .port_a_secondary_line(pa2),
		.shift_clock_line(sclk), .serial_in_line(sdin), .serial_out_line(sout), .irq_n(irq_n));
	tir_host_model host_u (.clk(clk), .chip_select(cs), .addr_strobe_n(as_n),
		.read_not_write(rnw), .register_select(sel), .data_in(din), .data_out(dout),
		.data_ack_n(ack_n));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e)
		begin
			err_count++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// one bus access, read data compared when r is set
	task automatic acc(input logic r, input logic [3:0] s, input logic [7:0] d, input logic [7:0] e);
		logic [7:0] q;
		bit         ok;
		host_u.access(r, s, d, q, ok);
		if (!ok)
			chk("ack", 8'h00, 8'hFF);
		if (r)
			chk("read", e, q);
	endtask : acc
	// request level, waited for at most lim cycles
	task automatic irq_is(input logic lvl, input int lim);
		int n;
		n = 0;
		#1;
		while (irq_n !== lvl && n < lim)
		begin
			@(posedge clk);
			#1 n++;
		end
		chk("irq_n", {7'h00, lvl}, {7'h00, irq_n});
	endtask : irq_is
	// eight shift clocks, data set on the fall and held past the rise;
	// the serial out bit is taken just before each rise
	task automatic shift8(input logic [7:0] b, output logic [7:0] q);
		#1;
		for (int i = 7; i >= 0; i--)
		begin
			sclk = 0;
			sdin = b[i];
			repeat (2) @(posedge clk);
			#1 q[i] = sout;
			sclk = 1;
			repeat (3) @(posedge clk);
			#1 sdin = ~b[i];
			repeat (3) @(posedge clk);
			#1;
		end
	endtask : shift8
	task automatic end_sim();
		$display("comparisons %0d mismatches %0d", checks, err_count);
		if (err_count == 0 && checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_sim
	initial
	begin
		repeat (2) @(posedge clk);
		#1 reset = 0;
		foreach (rows[i])
			acc(rows[i].r, rows[i].s, rows[i].d, rows[i].e);
		host_u.slow = 3;
		// timer1 one-shot: 32 cycle count
		acc(0, REG_ENABLES, 8'hC0, 0);
		acc(0, REG_T1_CNT_LO, 8'h20, 0);
		acc(0, REG_T1_CNT_HI, 8'h00, 0);
		irq_is(1, 0);
		irq_is(0, 60);
		acc(1, REG_T1_LAT_LO, 0, 8'h20);
		irq_is(0, 0);
		acc(0, REG_ENABLES, 8'h40, 0);
		irq_is(1, 3);
		acc(1, REG_FLAGS, 0, 8'h40);
		acc(0, REG_ENABLES, 8'hC0, 0);
		irq_is(0, 3);
		// counter ran 93 clocks past its load of 0x0020 and wrapped
		acc(1, REG_T1_CNT_LO, 0, 8'hC3);
		irq_is(1, 3);
		acc(0, REG_T1_CNT_HI, 8'h00, 0);
		irq_is(0, 60);
		acc(0, REG_T1_CNT_HI, 8'h00, 0);
		irq_is(1, 3);
		irq_is(0, 60);
		acc(0, REG_T1_LAT_HI, 8'h00, 0);
		irq_is(1, 3);
		// timer2 one-shot: 16 cycle count
		acc(0, REG_ENABLES, 8'h40, 0);
		acc(0, REG_ENABLES, 8'hA0, 0);
		acc(0, REG_T2_CNT_LO, 8'h10, 0);
		acc(0, REG_T2_CNT_HI, 8'h00, 0);
		irq_is(0, 40);
		acc(1, REG_T2_CNT_HI, 0, 8'hFF);
		irq_is(0, 0);
		acc(1, REG_T2_CNT_LO, 0, 8'hEA);
		irq_is(1, 3);
		// port a primary line, rising edge; pulses wide and spaced
		acc(0, REG_ENABLES, 8'h20, 0);
		acc(0, REG_LINE_CFG, 8'h01, 0);
		acc(0, REG_ENABLES, 8'h82, 0);
		#1 pa1 = 1;
		repeat (2) @(posedge clk);
		irq_is(0, 0);
		acc(1, REG_FLAGS, 0, 8'h82);
		acc(1, REG_PORT_A, 0, 8'h00);
		acc(1, REG_FLAGS, 0, 8'h00);
		#1 pa1 = 0;
		// secondary line as an independent input
		acc(0, REG_LINE_CFG, 8'h07, 0);
		acc(0, REG_ENABLES, 8'h81, 0);
		#1 pa2 = 1;
		acc(1, REG_PORT_A, 0, 8'h00);
		acc(1, REG_FLAGS, 0, 8'h81);
		acc(0, REG_FLAGS, 8'h01, 0);
		acc(1, REG_FLAGS, 0, 8'h00);
		#1 pa2 = 0;
		// shifter in then out; flag only after the eighth clock
		acc(0, REG_ENABLES, 8'h84, 0);
		acc(0, REG_AUX_CTRL, 8'h08, 0);
		acc(0, REG_SHIFTER, 8'h00, 0);
		shift8(8'hA5, sq);
		acc(1, REG_FLAGS, 0, 8'h84);
		acc(1, REG_SHIFTER, 0, 8'hA5);
		acc(1, REG_FLAGS, 0, 8'h00);
		acc(0, REG_AUX_CTRL, 8'h18, 0);
		acc(0, REG_SHIFTER, 8'h3C, 0);
		shift8(8'h00, sq);
		chk("serial_out_line", 8'h3C, sq);
		acc(1, REG_FLAGS, 0, 8'h84);
		// reset again mid-run
		#1 reset = 1;
		repeat (2) @(posedge clk);
		#1 reset = 0;
		irq_is(1, 0);
		acc(1, REG_ENABLES, 0, 8'h80);
		acc(1, REG_FLAGS, 0, 8'h00);
		end_sim();
	end
	// hang guard, far beyond the sequence length
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 6000)
		begin
			err_count++;
			end_sim();
		end
	end
endmodule : tir_timer_irq_test

// >>> hw/tir_pkg.sv
// constants for the timer and interrupt register block
package tir_pkg;
	// register select codes
	localparam logic [3:0] REG_PORT_B     = 4'h0;
	localparam logic [3:0] REG_PORT_A     = 4'h1;
	localparam logic [3:0] REG_T1_CNT_LO  = 4'h4;
	localparam logic [3:0] REG_T1_CNT_HI  = 4'h5;
	localparam logic [3:0] REG_T1_LAT_LO  = 4'h6;
	localparam logic [3:0] REG_T1_LAT_HI  = 4'h7;
	localparam logic [3:0] REG_T2_CNT_LO  = 4'h8;
	localparam logic [3:0] REG_T2_CNT_HI  = 4'h9;
	localparam logic [3:0] REG_SHIFTER    = 4'hA;
	localparam logic [3:0] REG_AUX_CTRL   = 4'hB;
	localparam logic [3:0] REG_LINE_CFG   = 4'hC;
	localparam logic [3:0] REG_FLAGS      = 4'hD;
	localparam logic [3:0] REG_ENABLES    = 4'hE;
	localparam logic [3:0] REG_PORT_A_NH  = 4'hF;
	// flag bit positions
	localparam int FLG_CA2 = 0;
	localparam int FLG_CA1 = 1;
	localparam int FLG_SHF = 2;
	localparam int FLG_CB2 = 3;
	localparam int FLG_CB1 = 4;
	localparam int FLG_T2  = 5;
	localparam int FLG_T1  = 6;
	localparam int FLG_IRQ = 7;
	localparam int ENA_SET = 7;
	// line config fields: bit0 ca1 rising, bits3:1 ca2 mode, bit4 cb1 rising, bits7:5 cb2 mode
	localparam int CFG_CA1_POS = 0;
	localparam int CFG_CA2_LSB = 1;
	localparam int CFG_CB1_POS = 4;
	localparam int CFG_CB2_LSB = 5;
	// aux control: bits4:2 shifter mode (bit4 set = shift out), bit6 timer1 free run
	localparam int AUX_SHF_OUT = 4;
	localparam int AUX_SHF_EN  = 3;
	localparam int AUX_T1_FREE = 6;
	localparam logic [7:0] RESET_BYTE = 8'h00;
	localparam logic [7:0] LINE_CFG_MASK = 8'h77;
	localparam logic [7:0] AUX_MASK      = 8'h5C;
	// bus acknowledge timing
	localparam int CLK_PERIOD_NS = 100;
	localparam int ACK_MIN_NS    = 590;
	localparam int ACK_MAX_NS    = 1870;
	localparam int ACK_CYCLES    = (ACK_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int SHIFT_BITS    = 8;
	// bus controller states
	typedef enum logic [1:0]
	{
		BUS_IDLE = 2'b00,
		BUS_WAIT = 2'b01,
		BUS_ACK  = 2'b10
	} tir_bus_t;
endpackage : tir_pkg

// >>> hw/tir_timer_irq.sv
// timers, interrupt flags, enables and bus handshake of the peripheral cell
// Contract
// - low counter write loads low latch only
// - high counter write loads, starts, clears flag
// - low counter read clears timer1 flag
// - low latch: write latch, read without clear
// - high latch write, no transfer, clears flag
// - timer2 low: latch write, read clears
// - timer2 high write loads counter, clears flag
// - port a line flags: edge set, access clear
// - port b line flags: edge set, access clear
// - shifter flag after eight bits, access clears
// - timer2 flag set on timeout only
// - timer1 flag set on timeout
// - summary flag follows enabled set flags
// - independent secondary lines cleared by flag write
// - enable write bit7 low disables ones
// - enable write bit7 high enables ones
// - enable read shows bit7 one
// - acknowledge 590 to 1870 ns after select; here five clocks after select is sampled, 500 to 600 ns
// - shift out advances on clock fall
// - shift in samples on clock rise
// - enabled edge raises request within 210 ns
// - select codes map timers, flags, enables
`timescale 1ns/1ns
module tir_timer_irq
(
	// clock and reset
	input  wire logic                  clk,
	input  wire logic                  reset,
	// processor bus
	input  wire logic                  chip_select,
	input  wire logic                  addr_strobe_n,
	input  wire logic                  read_not_write,
	input  wire logic [3:0]            register_select,
	input  wire logic [7:0]            data_in,
	output logic      [7:0]            data_out,
	output logic                       data_ack_n,
	// control lines
	input  wire logic                  port_a_primary_line,
	input  wire logic                  port_a_secondary_line,
	input  wire logic                  shift_clock_line,
	input  wire logic                  serial_in_line,
	output logic                       serial_out_line,
	// interrupt request
	output logic                       irq_n
);
	import tir_pkg::*;

	// bus handshake state
	tir_bus_t   bus_state_ff;               // bus controller
	logic [4:0] ack_cnt_ff;                 // wait count after select
	logic       access;                     // one-cycle access strobe
	logic       rd;                         // read strobe
	logic       wr;                         // write strobe
	// registers
	logic [7:0]  t1_lat_lo_ff;               // timer1 low latch
	logic [7:0]  t1_lat_hi_ff;               // timer1 high latch
	logic [15:0] t1_cnt_ff;                  // timer1 counter
	logic        t1_armed_ff;                // timer1 may still flag
	logic [7:0]  t2_lat_lo_ff;               // timer2 low latch
	logic [15:0] t2_cnt_ff;                  // timer2 counter
	logic        t2_armed_ff;                // timer2 one-shot armed
	logic [6:0]  flags_ff;                   // sticky interrupt flags
	logic [6:0]  enables_ff;                 // interrupt enables
	logic [7:0]  line_cfg_ff;                // control_line_config
	logic [7:0]  aux_ff;                     // aux control
	logic [7:0]  shifter_ff;                 // serial_shifter
	logic [3:0]  shift_cnt_ff;               // bits shifted so far
	// edge detection history
	logic        ca1_d_ff;
	logic        ca2_d_ff;
	logic        cb1_d_ff;
	logic        cb2_d_ff;
	logic        ca1_ev;
	logic        ca2_ev;
	logic        cb1_ev;
	logic        cb2_ev;
	logic        sclk_rise;
	logic        sclk_fall;
	logic        shift_active;
	logic        t1_timeout;
	logic        t2_timeout;
	logic [6:0]  flag_set;
	logic [6:0]  flag_clr;
	logic [7:0]  rd_data;

	// edge seen on a line, with chosen polarity
	function automatic logic edge_hit(input logic prev, input logic cur, input logic rising);
		edge_hit = rising ? (!prev && cur) : (prev && !cur);
	endfunction : edge_hit

	// secondary line configured as independent input (modes 001 and 011)
	function automatic logic indep(input logic [2:0] mode);
		indep = !mode[2] && mode[0];
	endfunction : indep

	// bus sequence: wait a fixed count after select, then acknowledge until select drops or strobe rises
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			bus_state_ff <= BUS_IDLE;
			ack_cnt_ff   <= 5'h00;
		end
		else
		begin
			case (bus_state_ff)
				BUS_IDLE:
				begin
					ack_cnt_ff <= 5'h00;
					if (chip_select && !addr_strobe_n)
						bus_state_ff <= BUS_WAIT;
				end
				BUS_WAIT:
				begin
					// access takes effect on the last wait cycle, ack follows
					ack_cnt_ff <= ack_cnt_ff + 5'h01;
					if (!chip_select)
						bus_state_ff <= BUS_IDLE;
					else if (ack_cnt_ff == 5'(ACK_CYCLES - 2))
						bus_state_ff <= BUS_ACK;
				end
				BUS_ACK:
				begin
					// hold until the master lets go of select or strobe
					if (!chip_select || addr_strobe_n)
						bus_state_ff <= BUS_IDLE;
				end
				default:
					bus_state_ff <= BUS_IDLE;
			endcase
		end
	end

	// access strobe: one cycle, on the last wait cycle, while select still stands
	assign access = (bus_state_ff == BUS_WAIT) && chip_select
		&& (ack_cnt_ff == 5'(ACK_CYCLES - 2));
	assign rd = access && read_not_write;
	assign wr = access && !read_not_write;

	// acknowledge and read data straight from flops
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			data_ack_n <= 1'b1;
			data_out   <= RESET_BYTE;
		end
		else
		begin
			data_ack_n <= !(access || (bus_state_ff == BUS_ACK && chip_select && !addr_strobe_n));
			if (rd)
				data_out <= rd_data;
		end
	end

	// read multiplexer
	// unmapped codes and the port registers read as zero
	always_comb
	begin
		case (register_select)
			REG_T1_CNT_LO: rd_data = t1_cnt_ff[7:0];
			REG_T1_CNT_HI: rd_data = t1_cnt_ff[15:8];
			REG_T1_LAT_LO: rd_data = t1_lat_lo_ff;
			REG_T1_LAT_HI: rd_data = t1_lat_hi_ff;
			REG_T2_CNT_LO: rd_data = t2_cnt_ff[7:0];
			REG_T2_CNT_HI: rd_data = t2_cnt_ff[15:8];
			REG_SHIFTER:   rd_data = shifter_ff;
			REG_AUX_CTRL:  rd_data = aux_ff;
			REG_LINE_CFG:  rd_data = line_cfg_ff;
			REG_FLAGS:     rd_data = {|(flags_ff & enables_ff), flags_ff};
			REG_ENABLES:   rd_data = {1'b1, enables_ff};
			default:       rd_data = RESET_BYTE;               // ports live elsewhere
		endcase
	end

	// control registers; latches are not cleared by reset in the original cell
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			line_cfg_ff <= RESET_BYTE;
			aux_ff      <= RESET_BYTE;
			enables_ff  <= 7'h00;
		end
		else if (wr)
		begin
			case (register_select)
				REG_LINE_CFG: line_cfg_ff <= data_in & LINE_CFG_MASK;
				REG_AUX_CTRL: aux_ff <= data_in & AUX_MASK;
				REG_ENABLES:
				begin
					if (data_in[ENA_SET])
						enables_ff <= enables_ff | data_in[6:0];
					else
						enables_ff <= enables_ff & ~data_in[6:0];
				end
				default: ;
			endcase
		end
	end

	// timer1 latches and timer2 low latch
	// no reset here: the timers stay undefined until the host writes them
	always_ff @(posedge clk)
	begin
		if (wr && (register_select == REG_T1_CNT_LO || register_select == REG_T1_LAT_LO))
			t1_lat_lo_ff <= data_in;
		if (wr && (register_select == REG_T1_CNT_HI || register_select == REG_T1_LAT_HI))
			t1_lat_hi_ff <= data_in;
		if (wr && register_select == REG_T2_CNT_LO)
			t2_lat_lo_ff <= data_in;
	end

	// timer1 counts down each clock; reload from latches in free-run mode
	assign t1_timeout = t1_armed_ff && (t1_cnt_ff == 16'h0000);
	always_ff @(posedge clk)
	begin
		if (reset)
			t1_armed_ff <= 1'b0;
		else if (wr && register_select == REG_T1_CNT_HI)
		begin
			t1_cnt_ff   <= {data_in, t1_lat_lo_ff};
			t1_armed_ff <= 1'b1;
		end
		else if (t1_cnt_ff == 16'h0000 && aux_ff[AUX_T1_FREE])
			t1_cnt_ff <= {t1_lat_hi_ff, t1_lat_lo_ff};
		else
		begin
			t1_cnt_ff <= t1_cnt_ff - 16'h0001;
			// one-shot flags only once per load
			if (t1_timeout && !aux_ff[AUX_T1_FREE])
				t1_armed_ff <= 1'b0;
		end
	end

	// timer2 one-shot
	assign t2_timeout = t2_armed_ff && (t2_cnt_ff == 16'h0000);
	always_ff @(posedge clk)
	begin
		if (reset)
			t2_armed_ff <= 1'b0;
		else if (wr && register_select == REG_T2_CNT_HI)
		begin
			t2_cnt_ff   <= {data_in, t2_lat_lo_ff};
			t2_armed_ff <= 1'b1;
		end
		else
		begin
			t2_cnt_ff <= t2_cnt_ff - 16'h0001;
			if (t2_timeout)
				t2_armed_ff <= 1'b0;
		end
	end

	// line history for edge detection
	// cleared to low; reset also picks falling edges, so no false edge follows
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			ca1_d_ff <= 1'b0;
			ca2_d_ff <= 1'b0;
			cb1_d_ff <= 1'b0;
			cb2_d_ff <= 1'b0;
		end
		else
		begin
			ca1_d_ff <= port_a_primary_line;
			ca2_d_ff <= port_a_secondary_line;
			cb1_d_ff <= shift_clock_line;
			cb2_d_ff <= serial_in_line;
		end
	end

	// mode bit1 of a secondary line picks the rising edge
	assign ca1_ev = edge_hit(ca1_d_ff, port_a_primary_line, line_cfg_ff[CFG_CA1_POS]);
	assign ca2_ev = !line_cfg_ff[CFG_CA2_LSB+2] && edge_hit(ca2_d_ff, port_a_secondary_line,
		line_cfg_ff[CFG_CA2_LSB+1]);
	assign cb1_ev = edge_hit(cb1_d_ff, shift_clock_line, line_cfg_ff[CFG_CB1_POS]);
	assign cb2_ev = !line_cfg_ff[CFG_CB2_LSB+2] && !aux_ff[AUX_SHF_EN]
		&& edge_hit(cb2_d_ff, serial_in_line, line_cfg_ff[CFG_CB2_LSB+1]);
	// shift clock edges are seen one clock late; its pulses are much longer
	assign sclk_rise = !cb1_d_ff && shift_clock_line;
	assign sclk_fall = cb1_d_ff && !shift_clock_line;
	assign shift_active = aux_ff[AUX_SHF_EN] && (shift_cnt_ff != 4'(SHIFT_BITS));

	// shifter under external shift clock
	always_ff @(posedge clk)
	begin
		if (reset)
		begin
			shift_cnt_ff    <= 4'h0;
			serial_out_line <= 1'b0;
		end
		else if (access && register_select == REG_SHIFTER)
		begin
			if (!read_not_write)
				shifter_ff <= data_in;
			shift_cnt_ff <= 4'h0; // any access restarts a byte
		end
		else if (shift_active && aux_ff[AUX_SHF_OUT] && sclk_fall)
		begin
			serial_out_line <= shifter_ff[7];
			shifter_ff      <= {shifter_ff[6:0], shifter_ff[7]};
			shift_cnt_ff    <= shift_cnt_ff + 4'h1;
		end
		else if (shift_active && !aux_ff[AUX_SHF_OUT] && sclk_rise)
		begin
			shifter_ff   <= {shifter_ff[6:0], serial_in_line};
			shift_cnt_ff <= shift_cnt_ff + 4'h1;
		end
	end

	// flag sources; set beats clear in the same cycle
	always_comb
	begin
		flag_set = 7'h00;
		flag_clr = 7'h00;
		flag_set[FLG_CA2] = ca2_ev;
		flag_set[FLG_CA1] = ca1_ev;
		flag_set[FLG_CB2] = cb2_ev;
		flag_set[FLG_CB1] = cb1_ev && !aux_ff[AUX_SHF_EN];
		flag_set[FLG_SHF] = shift_active && (shift_cnt_ff == 4'(SHIFT_BITS - 1))
			&& (aux_ff[AUX_SHF_OUT] ? sclk_fall : sclk_rise);
		flag_set[FLG_T2]  = t2_timeout;
		flag_set[FLG_T1]  = t1_timeout;
		if (access && (register_select == REG_PORT_A || register_select == REG_PORT_A_NH))
		begin
			flag_clr[FLG_CA1] = 1'b1;
			flag_clr[FLG_CA2] = !indep(line_cfg_ff[CFG_CA2_LSB +: 3]);
		end
		if (access && register_select == REG_PORT_B)
		begin
			flag_clr[FLG_CB1] = 1'b1;
			flag_clr[FLG_CB2] = !indep(line_cfg_ff[CFG_CB2_LSB +: 3]);
		end
		if (access && register_select == REG_SHIFTER)
			flag_clr[FLG_SHF] = 1'b1;
		if ((rd && register_select == REG_T2_CNT_LO) || (wr && register_select == REG_T2_CNT_HI))
			flag_clr[FLG_T2] = 1'b1;
		if ((rd && register_select == REG_T1_CNT_LO) || (wr && register_select == REG_T1_CNT_HI)
			|| (wr && register_select == REG_T1_LAT_HI))
			flag_clr[FLG_T1] = 1'b1;
		// a flag write clears every flag written as one, not only the lines
		if (wr && register_select == REG_FLAGS)
			flag_clr = flag_clr | data_in[6:0];
	end

	// sticky flags
	always_ff @(posedge clk)
	begin
		if (reset)
			flags_ff <= 7'h00;
		else
			flags_ff <= (flags_ff & ~flag_clr) | flag_set;
	end

	// request follows next flag state, one cycle after the edge
	// an enable write shows on the request one clock after it lands
	always_ff @(posedge clk)
	begin
		if (reset)
			irq_n <= 1'b1;
		else
			irq_n <= ~|((((flags_ff & ~flag_clr) | flag_set)) & enables_ff);
	end
endmodule : tir_timer_irq
